//--- verilog/acc_ctrl.v
// comparator channel control: settings, result sync, edge events, irq
// assumes analog core drives CMP_RAW asynchronously; avalon-mm master on MCLK
`timescale 1ns/100ps
`include "acc_map.vh"

// What this block does
// - comparator_on bit enables the comparator channel; clear disables it.
// - result_pin_drive bit puts result on result pin; clear keeps it internal.
// - result bit is one when positive exceeds negative; polarity_invert reverses.
// - low_power_select set tells analog core to run low power.
// - control bits 11 and 10 read zero and ignore writes.
// - selected event sets event flag; flag blocks further events until cleared.
// - edge select 11 signals events on any output change.
// - edge select 10: falling edges, or rising when inverted.
// - edge select 01: rising edges, or falling when inverted.
// - positive_input_select picks internal reference when set, input A otherwise.
// - negative select 11 half bandgap, 10 input D, 01 input C.
// - result pin comes straight from the comparator, unsynchronised.
// - event flag and result bit mirrored read-only into shared status.
module acc_ctrl (
    input  wire        MCLK,
    input  wire        RST_N,
    input  wire [3:0]  AVS_ADDRESS,
    input  wire        AVS_READ,
    input  wire        AVS_WRITE,
    input  wire [31:0] AVS_WRITEDATA,
    input  wire [3:0]  AVS_BYTEENABLE,
    output reg  [31:0] AVS_READDATA,
    output wire        AVS_WAITREQUEST,
    input  wire        CMP_RAW,
    output wire        CMP_ENABLE,
    output wire        CMP_LOW_POWER,
    output wire        POS_SEL_REF,
    output wire [1:0]  NEG_SEL,
    output wire        RESULT_PIN,
    output wire        RESULT_PIN_OE,
    output wire        EVENT_TRIGGER,
    output wire        IRQ
);

    // widths of the control word and its byte lanes
    localparam CTRL_W   = 16;
    localparam LANE_W   = 8;
    localparam LANES    = 2;
    // lane that carries the event flag, and the lane of the irq registers
    localparam EVT_LANE = 1;
    localparam IRQ_LANE = 0;

    // register state
    reg  [CTRL_W-1:0] ctrl_q;
    wire [CTRL_W-1:0] ctrl_d;
    reg               evt_q;
    reg               evt_d;
    reg               out_q;
    wire              out_d;
    reg               sync1_q;
    reg               sync2_q;
    reg               prev_q;
    wire              prev_d;
    reg               trig_q;
    wire              trig_d;
    reg               irq_stat_q;
    reg               irq_stat_d;
    reg               irq_mask_q;
    reg               irq_mask_d;
    reg               ack_q;
    wire              ack_d;
    reg  [31:0]       rdata_d;
    reg  [31:0]       stat_word;
    reg  [31:0]       irq_stat_word;
    reg  [31:0]       irq_mask_word;

    // decoded bus strobes
    wire              bus_req;
    wire              wr_acc;
    wire              rd_start;
    wire              at_ctrl;
    wire              at_irq_stat;
    wire              at_irq_mask;
    wire              ctrl_wr;
    wire              irq_stat_wr;
    wire              irq_mask_wr;
    wire [LANES-1:0]  lane_we;
    wire [CTRL_W-1:0] ctrl_wmask;
    wire [CTRL_W-1:0] wdata_m;

    // event path
    reg  [CTRL_W-1:0] ctrl_rd;
    wire              res_now;
    wire              rise;
    wire              fall;
    wire              hit;
    wire              evt_set;
    wire              evt_clr_wr;
    wire [1:0]        edge_sel;
    wire              pol;
    wire              chan_on;

    function sel_hit;
        input [3:0] a;
        input [3:0] ofs;
        begin
            sel_hit = (a == ofs);
        end
    endfunction

    // edges are judged on the polarity-adjusted result, so inversion swaps their sense
    function edge_hit;
        input [1:0] sel;
        input       up;
        input       down;
        begin
            case (sel)
                `ACC_EDGE_NONE: edge_hit = 1'b0;
                `ACC_EDGE_RISE: edge_hit = up;
                `ACC_EDGE_FALL: edge_hit = down;
                `ACC_EDGE_ANY:  edge_hit = up | down;
                default:        edge_hit = 1'b0;
            endcase
        end
    endfunction

    // address decode, shared by the write strobes
    assign at_ctrl     = sel_hit(AVS_ADDRESS, `ACC_OFS_CTRL);
    assign at_irq_stat = sel_hit(AVS_ADDRESS, `ACC_OFS_IRQ_STAT);
    assign at_irq_mask = sel_hit(AVS_ADDRESS, `ACC_OFS_IRQ_MASK);

    // one wait cycle per access keeps readdata registered
    assign bus_req         = AVS_READ | AVS_WRITE;
    assign AVS_WAITREQUEST = bus_req & ~ack_q;
    assign ack_d           = bus_req & ~ack_q;
    assign wr_acc          = AVS_WRITE & ack_q;
    assign rd_start        = AVS_READ & ~ack_q;
    assign ctrl_wr         = wr_acc & at_ctrl;
    assign irq_stat_wr     = wr_acc & at_irq_stat;
    assign irq_mask_wr     = wr_acc & at_irq_mask;
    assign ctrl_wmask      = `ACC_CTRL_WMASK;
    assign wdata_m         = AVS_WRITEDATA[CTRL_W-1:0] & ctrl_wmask;

    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
        end
    end

    // control word written lane by lane through the write mask
    genvar lane;
    generate
        for (lane = 0; lane < LANES; lane = lane + 1) begin : g_lane
            assign lane_we[lane] = ctrl_wr & AVS_BYTEENABLE[lane];
            assign ctrl_d[lane*LANE_W +: LANE_W] = lane_we[lane] ?
                wdata_m[lane*LANE_W +: LANE_W] :
                ctrl_q[lane*LANE_W +: LANE_W];
        end
    endgenerate

    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_q <= `ACC_CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // channel settings straight from the control word
    assign chan_on       = ctrl_q[`ACC_BIT_ON];
    assign pol           = ctrl_q[`ACC_BIT_POL];
    assign edge_sel      = ctrl_q[`ACC_EDGE_HI:`ACC_EDGE_LO];
    assign CMP_ENABLE    = chan_on;
    assign CMP_LOW_POWER = ctrl_q[`ACC_BIT_LPWR];
    assign POS_SEL_REF   = ctrl_q[`ACC_BIT_PSEL];
    assign NEG_SEL       = ctrl_q[`ACC_NSEL_HI:`ACC_NSEL_LO];
    assign RESULT_PIN_OE = ctrl_q[`ACC_BIT_OE];
    // pin path bypasses the synchroniser, so comparator glitches reach the pad
    assign RESULT_PIN    = (CMP_RAW ^ pol) & chan_on;

    // two-stage synchroniser; only the second stage feeds logic
    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            sync1_q <= 1'b0;
        end else begin
            sync1_q <= CMP_RAW;
        end
    end

    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            sync2_q <= 1'b0;
        end else begin
            sync2_q <= sync1_q;
        end
    end

    // result forced low while off; events are gated by the enable as well
    assign res_now = (sync2_q ^ pol) & chan_on;
    assign rise    = res_now & ~prev_q;
    assign fall    = ~res_now & prev_q;
    assign prev_d  = res_now;
    assign out_d   = res_now;
    assign hit     = edge_hit(edge_sel, rise, fall);
    assign evt_set = hit & ~evt_q & chan_on;
    assign trig_d  = evt_set;

    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
        end
    end

    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            out_q <= 1'b0;
        end else begin
            out_q <= out_d;
        end
    end

    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= trig_d;
        end
    end

    assign EVENT_TRIGGER = trig_q;

    // event flag: software writes its lane; a hardware set in the same cycle wins
    assign evt_clr_wr = ctrl_wr & AVS_BYTEENABLE[EVT_LANE];

    always @* begin
        evt_d = evt_q;
        if (evt_set) begin
            evt_d = 1'b1;
        end else if (evt_clr_wr) begin
            evt_d = AVS_WRITEDATA[`ACC_BIT_EVT];
        end
    end

    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            evt_q <= 1'b0;
        end else begin
            evt_q <= evt_d;
        end
    end

    // sticky status, write one to clear; a set in the same cycle wins
    always @* begin
        irq_stat_d = irq_stat_q;
        if (evt_set) begin
            irq_stat_d = 1'b1;
        end else if (irq_stat_wr && AVS_BYTEENABLE[IRQ_LANE] && AVS_WRITEDATA[`ACC_IRQ_EVENT]) begin
            irq_stat_d = 1'b0;
        end
    end

    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_stat_q <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
        end
    end

    always @* begin
        irq_mask_d = irq_mask_q;
        if (irq_mask_wr && AVS_BYTEENABLE[IRQ_LANE]) begin
            irq_mask_d = AVS_WRITEDATA[`ACC_IRQ_EVENT];
        end
    end

    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_mask_q <= 1'b0;
        end else begin
            irq_mask_q <= irq_mask_d;
        end
    end

    // level interrupt, held until status is cleared or masked
    assign IRQ = irq_stat_q & irq_mask_q;

    // control readback: masked storage with live flag and result bits
    always @* begin
        ctrl_rd = ctrl_q & ctrl_wmask;
        ctrl_rd[`ACC_BIT_EVT] = evt_q;
        ctrl_rd[`ACC_BIT_OUT] = out_q;
    end

    // status words; the shared status only mirrors, it keeps no storage
    always @* begin
        stat_word = 32'h00000000;
        stat_word[`ACC_STAT_EVT] = evt_q;
        stat_word[`ACC_STAT_OUT] = out_q;
    end

    always @* begin
        irq_stat_word = 32'h00000000;
        irq_stat_word[`ACC_IRQ_EVENT] = irq_stat_q;
    end

    always @* begin
        irq_mask_word = 32'h00000000;
        irq_mask_word[`ACC_IRQ_EVENT] = irq_mask_q;
    end

    // read mux; unmapped offsets read zero
    always @* begin
        case (AVS_ADDRESS)
            `ACC_OFS_CTRL: begin
                rdata_d = {16'h0000, ctrl_rd};
            end
            `ACC_OFS_STAT: begin
                rdata_d = stat_word;
            end
            `ACC_OFS_IRQ_STAT: begin
                rdata_d = irq_stat_word;
            end
            `ACC_OFS_IRQ_MASK: begin
                rdata_d = irq_mask_word;
            end
            default: begin
                rdata_d = 32'h00000000;
            end
        endcase
    end

    // readdata loads in the wait cycle and then holds until the next read,
    // so the master may take it at the edge where waitrequest is low
    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            AVS_READDATA <= 32'h00000000;
        end else if (rd_start) begin
            AVS_READDATA <= rdata_d;
        end
    end

endmodule

//--- verilog/acc_map.vh
// register map and field positions for the comparator channel control block
// assumes a 32-bit avalon-mm slave with word addresses in bytes
`ifndef ACC_MAP_VH
`define ACC_MAP_VH

`define ACC_ADDR_W        4
`define ACC_OFS_CTRL      4'h0
`define ACC_OFS_STAT      4'h4
`define ACC_OFS_IRQ_STAT  4'h8
`define ACC_OFS_IRQ_MASK  4'hC

`define ACC_CTRL_WMASK    16'hF2D3
`define ACC_CTRL_RESET    16'h0000

`define ACC_BIT_ON        15
`define ACC_BIT_OE        14
`define ACC_BIT_POL       13
`define ACC_BIT_LPWR      12
`define ACC_BIT_EVT       9
`define ACC_BIT_OUT       8
`define ACC_EDGE_HI       7
`define ACC_EDGE_LO       6
`define ACC_BIT_PSEL      4
`define ACC_NSEL_HI       1
`define ACC_NSEL_LO       0

`define ACC_EDGE_NONE     2'h0
`define ACC_EDGE_RISE     2'h1
`define ACC_EDGE_FALL     2'h2
`define ACC_EDGE_ANY      2'h3

`define ACC_NSEL_B        2'h0
`define ACC_NSEL_C        2'h1
`define ACC_NSEL_D        2'h2
`define ACC_NSEL_HALFBG   2'h3

`define ACC_IRQ_EVENT     0

`define ACC_STAT_EVT      9
`define ACC_STAT_OUT      0
`endif

//--- tb/acc_ctrl_sva.sv
// checker of acc_ctrl port timing
// bound to every acc_ctrl instance, sees its ports only
`timescale 1ns/100ps
module acc_ctrl_sva (
    input wire        MCLK,
    input wire        RST_N,
    input wire        AVS_READ,
    input wire        AVS_WRITE,
    input wire        AVS_WAITREQUEST,
    input wire        CMP_ENABLE,
    input wire        CMP_LOW_POWER,
    input wire        POS_SEL_REF,
    input wire        RESULT_PIN_OE,
    input wire        EVENT_TRIGGER,
    input wire [3:0]  AVS_ADDRESS,
    input wire [3:0]  AVS_BYTEENABLE,
    input wire [31:0] AVS_WRITEDATA,
    input wire [31:0] AVS_READDATA,
    input wire [1:0]  NEG_SEL
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    wire w0 = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 4'h0;
    wire h1 = w0 && AVS_BYTEENABLE[1];
    wire h0 = w0 && AVS_BYTEENABLE[0];
    AST_WAIT: assert property ($rose(AVS_READ | AVS_WRITE) |->
        AVS_WAITREQUEST ##1 !AVS_WAITREQUEST) else $error("bus wait wrong");
    AST_ON: assert property (h1 |=> CMP_ENABLE == $past(AVS_WRITEDATA[15])) else $error("on");
    AST_OE: assert property (h1 |=> RESULT_PIN_OE == $past(AVS_WRITEDATA[14])) else $error("oe");
    AST_LP: assert property (h1 |=> CMP_LOW_POWER == $past(AVS_WRITEDATA[12])) else $error("lp");
    AST_PS: assert property (h0 |=> POS_SEL_REF == $past(AVS_WRITEDATA[4])) else $error("ps");
    AST_NS: assert property (h0 |=> NEG_SEL == $past(AVS_WRITEDATA[1:0])) else $error("ns");
    AST_RES0: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 4'h0 |->
        AVS_READDATA[11:10] == 2'b00) else $error("reserved bits set");
    AST_PULSE: assert property (EVENT_TRIGGER |=> !EVENT_TRIGGER [*2]) else $error("retrigger");
endmodule
bind acc_ctrl acc_ctrl_sva acc_ctrl_sva_i (.*);

//--- tb/acc_cmp_model.sv
// analog side: input multiplexers and comparator core
// source levels come from the bench as six bytes: a, ref, b, c, d, half bandgap
`timescale 1ns/100ps
module acc_cmp_model (
    input  wire        en,
    input  wire        pos_ref,
    input  wire [1:0]  neg_sel,
    input  wire [47:0] lvl,
    output wire        raw
);
    wire [7:0] pos = pos_ref ? lvl[15:8] : lvl[7:0];
    wire [7:0] neg = lvl[8 * neg_sel + 16 +: 8];
    // core output parked low while the channel is off
    assign raw = en & (pos > neg);
endmodule

//--- tb/acc_ctrl_tb.sv
// random and corner tests of acc_ctrl with a behavioural comparator
// uses acc_map.vh offsets and the one-wait avalon-mm answer
`timescale 1ns/100ps
`include "acc_map.vh"
module acc_ctrl_tb;
    reg         MCLK = 1'b0, RST_N = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
    reg  [3:0]  AVS_ADDRESS = 4'h0, AVS_BYTEENABLE = 4'h3;
    reg  [31:0] AVS_WRITEDATA = 32'h0, q, seed = 32'h3071;
    reg  [47:0] lvl = 48'h0;
    reg  [15:0] d;
    wire [31:0] AVS_READDATA;
    wire        AVS_WAITREQUEST, CMP_RAW, CMP_ENABLE, CMP_LOW_POWER, POS_SEL_REF;
    wire        RESULT_PIN, RESULT_PIN_OE, EVENT_TRIGGER, IRQ;
    wire [1:0]  NEG_SEL;
    integer     mismatches = 0, comparisons = 0, trigs = 0, i, m;
    acc_ctrl acc_ctrl_i (.*);
    acc_cmp_model acc_cmp_model_i (.en(CMP_ENABLE), .pos_ref(POS_SEL_REF),
        .neg_sel(NEG_SEL), .lvl(lvl), .raw(CMP_RAW));
    initial forever #50 MCLK = ~MCLK;
    always @(posedge MCLK) if (EVENT_TRIGGER === 1'b1) trigs = trigs + 1;
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function res(input [15:0] c, input [47:0] v);
        res = c[15] & (((c[4] ? v[15:8] : v[7:0]) > v[8 * c[1:0] + 16 +: 8]) ^ c[13]);
    endfunction
    task bus(input w, input [3:0] a, input [31:0] v);
        begin
            @(posedge MCLK);
            AVS_READ <= ~w;
            AVS_WRITE <= w;
            AVS_ADDRESS <= a;
            AVS_WRITEDATA <= v;
            do @(posedge MCLK); while (AVS_WAITREQUEST !== 1'b0);
            q = AVS_READDATA;
            AVS_READ <= 1'b0;
            AVS_WRITE <= 1'b0;
        end
    endtask
    task chk(input string n, input [15:0] e, input [15:0] g);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("[FAIL] %0s expected %h seen %h", n, e, g);
            end
        end
    endtask
    task print_verdict;
        begin
            if (mismatches == 0 && comparisons > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    initial begin
        #3000000;
        mismatches = mismatches + 1;
        print_verdict;
    end
    initial begin
        repeat (4) @(posedge MCLK);
        RST_N <= 1'b1;
        bus(0, `ACC_OFS_CTRL, 0);
        chk("ctrl_rst", `ACC_CTRL_RESET, q[15:0]);
        bus(0, 4'h1, 0);
        chk("unmapped", 0, q[15:0]);
        for (i = 0; i < 24; i = i + 1) begin
            seed = lfsr(seed);
            lvl <= {lvl[15:0], seed};
            d = seed[31:16] & 16'hFDFF;
            bus(1, `ACC_OFS_CTRL, d);
            repeat (6) @(posedge MCLK);
            bus(0, `ACC_OFS_CTRL, 0);
            chk("ctrl", d & 16'hF0D3, q[15:0] & 16'hFCFF);
            bus(0, `ACC_OFS_STAT, 0);
            chk("result", res(d, lvl), q[0]);
            if (d[14]) chk("pin", res(d, lvl), RESULT_PIN);
        end
        // mode written only after the channel settles, so switching on is no event
        for (m = 0; m < 8; m = m + 1) begin
            lvl <= 48'h0000_0014_000A;
            d = {1'b1, 1'b0, m[2], 5'h0, m[1:0], 6'h0};
            bus(1, `ACC_OFS_IRQ_MASK, {31'h0, ~m[2]});
            bus(1, `ACC_OFS_IRQ_STAT, 1);
            bus(1, `ACC_OFS_CTRL, d & 16'hFF3F);
            repeat (6) @(posedge MCLK);
            chk("irq_clr", 0, IRQ);
            bus(1, `ACC_OFS_CTRL, d);
            trigs = 0;
            lvl <= 48'h0000_0014_001E;
            repeat (8) @(posedge MCLK);
            lvl <= 48'h0000_0014_000A;
            repeat (8) @(posedge MCLK);
            chk("trigs", m[0] | m[1], trigs[15:0]);
            bus(0, `ACC_OFS_CTRL, 0);
            chk("flag", m[0] | m[1], q[9]);
            bus(0, `ACC_OFS_STAT, 0);
            chk("mirror", m[0] | m[1], q[9]);
            chk("irq", (m[0] | m[1]) & ~m[2], IRQ);
        end
        print_verdict;
    end
endmodule
